// *** inc/mrfts_pkg.sv ***
// Constants and carrier types for the receive filter and transmit status block.
// Assumes a 100 MHz core clock and a 10 Mb/s line (one bit time is 100 ns).
`default_nettype none

package mrfts_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte offsets in the register page)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_ACCEPT = 12'h104;
  localparam logic [11:0] OFS_TXEN   = 12'h106;
  localparam logic [11:0] OFS_EVENTS = 12'h128;
  localparam logic [11:0] OFS_STA0   = 12'h158;
  localparam logic [11:0] OFS_STA1   = 12'h15a;
  localparam logic [11:0] OFS_STA2   = 12'h15c;

  // ----------------------------------------------------------------------
  // Reset values, identifier codes and writable masks
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_ACCEPT = 16'h0005;
  localparam logic [15:0] RST_TXEN   = 16'h0007;
  localparam logic [15:0] RST_EVENTS = 16'h0008;
  localparam logic [5:0]  ID_ACCEPT  = 6'h05;
  localparam logic [5:0]  ID_TXEN    = 6'h07;
  localparam logic [5:0]  ID_EVENTS  = 6'h08;
  localparam logic [15:0] WMASK_ACCEPT = 16'h7fc0;
  localparam logic [15:0] WMASK_TXEN   = 16'h8fc0;
  localparam logic [15:0] IRQ_EVT_MASK = 16'h87c0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACC_HASHED_STATION = 6;
  localparam int ACC_ANY_ADDRESS    = 7;
  localparam int ACC_GOOD_FRAME     = 8;
  localparam int ACC_HASHED_GROUP   = 9;
  localparam int ACC_STATION_MATCH  = 10;
  localparam int ACC_ALL_STATIONS   = 11;
  localparam int ACC_BAD_CHECKSUM   = 12;
  localparam int ACC_SHORT_FRAME    = 13;
  localparam int ACC_LONG_FRAME     = 14;
  localparam int EVT_LOST_CARRIER   = 6;
  localparam int EVT_HEARTBEAT      = 7;
  localparam int EVT_SUCCESS        = 8;
  localparam int EVT_LATE_COLL      = 9;
  localparam int EVT_OVERLONG       = 10;
  localparam int EVT_COLL_LSB       = 11;
  localparam int EVT_EXCESS_COLL    = 15;

  // ----------------------------------------------------------------------
  // Frame lengths and collision limit
  // ----------------------------------------------------------------------
  localparam logic [15:0] LEN_MIN_KEEP = 16'h0008;
  localparam logic [15:0] LEN_MIN_GOOD = 16'h0040;
  localparam logic [15:0] LEN_MAX_GOOD = 16'h05ee;
  localparam logic [3:0]  COLL_LAST_NORMAL = 4'hf;

  // ----------------------------------------------------------------------
  // Times and derived cycle counts
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS   = 100;
  localparam int LATE_BITS     = 512;
  localparam int HB_BITS       = 64;
  localparam int JABBER_MS     = 26;
  // Least time: round up
  localparam int LATE_CYC = (LATE_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time: round down
  localparam int HB_CYC = (HB_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int JABBER_CYC = (JABBER_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [15:0] wdata;
  } mrfts_reg_req_type;

  typedef struct packed {
    logic        load;
    logic        accept_valid;
    logic [15:0] accept_value;
    logic        txen_valid;
    logic [15:0] txen_value;
  } mrfts_preload_type;

  typedef struct packed {
    logic        done;
    logic [47:0] dest;
    logic [15:0] len;
    logic        crc_ok;
    logic        hash_hit;
  } mrfts_rx_report_type;

  typedef struct packed {
    logic        valid;
    logic        accept;
    logic [15:0] kept_len;
  } mrfts_verdict_type;

  typedef struct packed {
    logic start;
    logic first;
    logic aui;
    logic preamble_end;
    logic carrier;
    logic collision;
    logic sent;
  } mrfts_tx_line_type;

endpackage

`default_nettype wire

// *** hw/mrfts_addr_filter.sv ***
// Destination address filter and frame class check, purely combinational.
// Assumes the caller registers the verdict; octet 0 of the address is in bits 7:0.
`timescale 1ns/1ps
`default_nettype none

module mrfts_addr_filter
  import mrfts_pkg::*;
(
  input  wire logic [15:0]         accept_cfg,
  input  wire logic [47:0]         station,
  input  wire mrfts_rx_report_type rep,
  output logic                     accept,
  output logic [15:0]              kept_len
);

  logic pass;
  logic group;
  logic all_ones;
  logic crc_fine;
  logic is_short;
  logic is_long;

  // --------------------------------------------------------------------
  // Address filter
  // --------------------------------------------------------------------
  // R3 R4 R5 R6 R7 address terms
  always_comb
  begin
    group    = rep.dest[0];
    all_ones = &rep.dest;
    pass     = accept_cfg[ACC_ANY_ADDRESS]
             | (accept_cfg[ACC_HASHED_STATION] & ~group & rep.hash_hit)
             | (accept_cfg[ACC_HASHED_GROUP] & group & rep.hash_hit)
             | (accept_cfg[ACC_STATION_MATCH] & (rep.dest == station))
             | (accept_cfg[ACC_ALL_STATIONS] & all_ones);
  end

  // --------------------------------------------------------------------
  // Frame class check
  // --------------------------------------------------------------------
  always_comb
  begin
    crc_fine = rep.crc_ok | accept_cfg[ACC_BAD_CHECKSUM];
    is_short = rep.len < LEN_MIN_GOOD;
    is_long  = rep.len > LEN_MAX_GOOD;
    if (rep.len < LEN_MIN_KEEP)
      accept = 1'b0;
    else if (is_short)
      accept = pass & crc_fine & accept_cfg[ACC_SHORT_FRAME];
    else if (is_long)
      accept = pass & crc_fine & accept_cfg[ACC_LONG_FRAME];
    else if (rep.crc_ok)
      accept = pass & accept_cfg[ACC_GOOD_FRAME];
    else
      accept = pass & accept_cfg[ACC_BAD_CHECKSUM];
    // Long frames keep only the first bytes up to the maximum size
    kept_len = is_long ? LEN_MAX_GOOD : rep.len;
  end

endmodule // mrfts_addr_filter

`default_nettype wire

// *** hw/mrfts_span_counter.sv ***
// Cycle counter that runs while run is high and clears when it drops.
// Assumes an asynchronous active-low reset whose release is already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module mrfts_span_counter #(
  parameter int W     = 13,
  parameter int LIMIT = 100
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic run,
  output logic      done
);

  localparam logic [W-1:0] LIM = W'(LIMIT);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } mrfts_span_type;

  mrfts_span_type q;
  mrfts_span_type next_q;

  // Saturates at the limit so done stays up until run drops
  always_comb
  begin
    next_q = q;
    if (!run)
      next_q = '0;
    else if (q.cnt != LIM)
      next_q.cnt = q.cnt + 1'b1;
    next_q.done = run && (next_q.cnt == LIM);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= next_q;
  end

  assign done = q.done;

endmodule // mrfts_span_counter

`default_nettype wire

// *** hw/mrfts_top.sv ***
// Receive acceptance filter and transmit outcome status for a 10 Mb/s MAC.
// Assumes the MAC core reports frames and line events synchronous to ref_clk.
//
// How it works
// R1: Low six register bits read fixed codes
// R2: Frame accepted only when address filter passes
// R3: Any-address bit passes every destination
// R4: Hashed individual addresses pass when enabled
// R5: Hashed group addresses pass when enabled
// R6: Station address match passes when enabled
// R7: All-ones destination passes when enabled
// R8: Good frames 64..1518 bytes kept when enabled
// R9: Bad checksum frames kept only if enabled
// R10: Short frames kept only if enabled
// R11: Frames under 8 bytes always dropped
// R12: Long frames cut at 1518 or dropped
// R13: Reset values 0005h/0007h, optional preload
// R14: Enable bits only gate transmit interrupts
// R15: Lost carrier on AUI sets flag
// R16: No heartbeat within 64 bits sets flag
// R17: Success only when clean send finished
// R18: Late collision forces bad checksum, ends send
// R19: Overlong send cut off and flagged
// R20: Collision count field; interrupt after collided send
// R21: Sixteenth collision abandons packet, sets flag
// R22: Reading event register clears it; host handles all
// R23: Enabled event shows register in status queue
`timescale 1ns/1ps
`default_nettype none

module mrfts_top
  import mrfts_pkg::*;
#(
  parameter int LATE_CYCLES   = LATE_CYC,
  parameter int JABBER_CYCLES = JABBER_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  input  wire mrfts_reg_req_type   reg_req,
  output logic [15:0]              reg_rdata,
  input  wire mrfts_preload_type   preload,
  input  wire mrfts_rx_report_type rx_rep,
  output mrfts_verdict_type        verdict,
  input  wire mrfts_tx_line_type   tx_line,
  output logic                     tx_cut,
  output logic                     tx_bad_crc,
  output logic                     tx_irq,
  output logic [15:0]              isq_word
);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_BEAT = 3'b100
  } mrfts_tx_state_type;

  typedef struct packed {
    logic [15:0]        accept_cfg;
    logic [15:0]        txen_cfg;
    logic [47:0]        station;
    logic [15:0]        events;
    mrfts_tx_state_type st;
    logic [3:0]         colls;
    logic               pkt_bad;
    logic               coll_q;
    logic [15:0]        rdata;
    mrfts_verdict_type  verdict;
    logic               cut;
    logic               bad_crc;
    logic               irq;
    logic [15:0]        interrupt_status_queue;
  } mrfts_state_type;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Readback merges stored bits with the fixed identifier
  function automatic logic [15:0] with_id(input logic [15:0] v, input logic [5:0] id);
    with_id = {v[15:6], id};
  endfunction

  // Masked write keeps bits outside the writable set
  function automatic logic [15:0] masked(input logic [15:0] old, input logic [15:0] nv,
                                         input logic [15:0] m);
    masked = (old & ~m) | (nv & m);
  endfunction

  // ----------------------------------------------------------------------
  // State and submodules
  // ----------------------------------------------------------------------
  mrfts_state_type q;
  mrfts_state_type next_q;

  logic        rx_accept;
  logic [15:0] rx_kept;
  logic        late_win;
  logic        jabber_hit;
  logic        beat_over;

  // R2 address filter
  mrfts_addr_filter u_filter (
    .accept_cfg (q.accept_cfg),
    .station    (q.station),
    .rep        (rx_rep),
    .accept     (rx_accept),
    .kept_len   (rx_kept)
  );

  // R18 late window
  mrfts_span_counter #(
    .W     (16),
    .LIMIT (LATE_CYCLES)
  ) u_late (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (q.st == TX_SEND),
    .done    (late_win)
  );

  // R19 jabber timer
  mrfts_span_counter #(
    .W     (24),
    .LIMIT (JABBER_CYCLES)
  ) u_jabber (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (q.st == TX_SEND),
    .done    (jabber_hit)
  );

  // R16 heartbeat window
  mrfts_span_counter #(
    .W     (12),
    .LIMIT (HB_CYC)
  ) u_beat (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (q.st == TX_BEAT),
    .done    (beat_over)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic [15:0] set_vec;
  logic        coll_edge;
  logic        finish;
  logic        any_coll_irq;
  logic        read_events;
  logic [3:0]  colls_inc;

  always_comb
  begin
    next_q       = q;
    set_vec      = '0;
    finish       = 1'b0;
    any_coll_irq = 1'b0;
    coll_edge    = tx_line.collision & ~q.coll_q;
    colls_inc    = q.colls + 4'h1;
    read_events  = reg_req.rd && (reg_req.addr == OFS_EVENTS);

    next_q.coll_q  = tx_line.collision;
    next_q.cut     = 1'b0;
    next_q.bad_crc = 1'b0;
    next_q.irq     = 1'b0;

    // R13 preload from configuration memory
    if (preload.load && preload.accept_valid)
      next_q.accept_cfg = masked(q.accept_cfg, preload.accept_value, WMASK_ACCEPT);
    if (preload.load && preload.txen_valid)
      next_q.txen_cfg = masked(q.txen_cfg, preload.txen_value, WMASK_TXEN);

    // Host writes; the event register ignores them
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        OFS_ACCEPT: next_q.accept_cfg = masked(q.accept_cfg, reg_req.wdata, WMASK_ACCEPT);
        OFS_TXEN:   next_q.txen_cfg = masked(q.txen_cfg, reg_req.wdata, WMASK_TXEN);
        OFS_STA0:   next_q.station[15:0] = reg_req.wdata;
        OFS_STA1:   next_q.station[31:16] = reg_req.wdata;
        OFS_STA2:   next_q.station[47:32] = reg_req.wdata;
        default:    next_q.station = q.station;
      endcase
    end

    // R1 readback with identifier codes
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        OFS_ACCEPT: next_q.rdata = with_id(q.accept_cfg, ID_ACCEPT);
        OFS_TXEN:   next_q.rdata = with_id(q.txen_cfg, ID_TXEN);
        OFS_EVENTS: next_q.rdata = with_id(q.events, ID_EVENTS);
        OFS_STA0:   next_q.rdata = q.station[15:0];
        OFS_STA1:   next_q.rdata = q.station[31:16];
        OFS_STA2:   next_q.rdata = q.station[47:32];
        default:    next_q.rdata = 16'h0000;
      endcase
    end

    // R8 R9 R10 R11 R12 per-frame verdict
    next_q.verdict.valid    = rx_rep.done;
    next_q.verdict.accept   = rx_rep.done & rx_accept;
    next_q.verdict.kept_len = rx_rep.done ? rx_kept : q.verdict.kept_len;

    // --------------------------------------------------------------------
    // Transmit outcome tracking
    // --------------------------------------------------------------------
    unique case (q.st)
      TX_IDLE, TX_BEAT:
      begin
        // R16 heartbeat missing after an AUI send
        if (q.st == TX_BEAT && !tx_line.start)
        begin
          if (coll_edge)
            next_q.st = TX_IDLE;
          else if (beat_over)
          begin
            set_vec[EVT_HEARTBEAT] = 1'b1;
            next_q.st = TX_IDLE;
          end
        end
        if (tx_line.start)
        begin
          next_q.st = TX_SEND;
          if (tx_line.first)
          begin
            next_q.colls   = 4'h0;
            next_q.pkt_bad = 1'b0;
          end
        end
      end
      TX_SEND:
      begin
        // R15 carrier missing at preamble end
        if (tx_line.preamble_end && tx_line.aui && !tx_line.carrier)
          set_vec[EVT_LOST_CARRIER] = 1'b1;
        if (jabber_hit)
        begin
          // R19 jabber cut-off
          set_vec[EVT_OVERLONG] = 1'b1;
          next_q.cut     = 1'b1;
          next_q.pkt_bad = 1'b1;
          finish         = 1'b1;
        end
        else if (coll_edge && late_win)
        begin
          // R18 late collision
          set_vec[EVT_LATE_COLL] = 1'b1;
          next_q.cut     = 1'b1;
          next_q.bad_crc = 1'b1;
          next_q.pkt_bad = 1'b1;
          finish         = 1'b1;
        end
        else if (coll_edge && q.colls == COLL_LAST_NORMAL)
        begin
          // R21 sixteenth normal collision abandons the packet
          set_vec[EVT_EXCESS_COLL] = 1'b1;
          next_q.cut     = 1'b1;
          next_q.pkt_bad = 1'b1;
          finish         = 1'b1;
        end
        else if (coll_edge)
        begin
          // Attempt over; the core backs off and restarts
          next_q.colls = colls_inc;
          next_q.st    = TX_IDLE;
        end
        else if (tx_line.sent)
        begin
          // R17 clean completion only
          set_vec[EVT_SUCCESS] = ~q.pkt_bad;
          finish = 1'b1;
        end
      end
      default:
        next_q.st = TX_IDLE;
    endcase

    if (finish)
    begin
      next_q.st = tx_line.aui ? TX_BEAT : TX_IDLE;
      // R20 collision count and end-of-send interrupt
      set_vec[EVT_COLL_LSB +: 4] = q.colls;
      any_coll_irq = (q.colls != 4'h0) & q.txen_cfg[EVT_COLL_LSB];
    end

    // R22 clear on read, hardware set wins
    next_q.events = (read_events ? RST_EVENTS : q.events) | (set_vec & IRQ_EVT_MASK);
    if (finish)
      next_q.events[EVT_COLL_LSB +: 4] = q.colls;

    // R14 R23 enabled event raises interrupt and queue word
    if (|(set_vec & q.txen_cfg & IRQ_EVT_MASK) || any_coll_irq)
    begin
      next_q.irq = 1'b1;
      next_q.interrupt_status_queue = with_id(next_q.events, ID_EVENTS);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // R13 reset values; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q            <= '0;
      q.accept_cfg <= RST_ACCEPT;
      q.txen_cfg   <= RST_TXEN;
      q.events     <= RST_EVENTS;
      q.st         <= TX_IDLE;
    end
    else if (ce)
      q <= next_q;
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign reg_rdata  = q.rdata;
  assign verdict    = q.verdict;
  assign tx_cut     = q.cut;
  assign tx_bad_crc = q.bad_crc;
  assign tx_irq     = q.irq;
  assign isq_word   = q.interrupt_status_queue;

endmodule // mrfts_top

`default_nettype wire

// *** test/mrfts_medium_model.sv ***
// Far-side model: line events of one send attempt.
// Assumes ref_clk at 100 MHz; all levels except aui idle low between attempts.
`timescale 1ns/1ps
`default_nettype none

module mrfts_medium_model
  import mrfts_pkg::*;
(
  input  wire logic         ref_clk,
  output mrfts_tx_line_type tx_line
);
  initial tx_line = '0;

  // One attempt; kind 0 ends sent, 1 ends in collision, 2 never ends
  // Carrier drops after each attempt
  task automatic attempt(input logic first, aui, crs, input int cyc, kind);
    @(posedge ref_clk);
    #1 tx_line.start = '1;
    tx_line.first = first;
    tx_line.aui = aui;
    @(posedge ref_clk);
    #1 tx_line.start = '0;
    tx_line.first = '0;
    tx_line.preamble_end = '1;
    tx_line.carrier = crs;
    @(posedge ref_clk);
    #1 tx_line.preamble_end = '0;
    repeat (cyc) @(posedge ref_clk);
    #1 tx_line.sent = (kind == 0);
    tx_line.collision = (kind == 1);
    @(posedge ref_clk);
    #1 tx_line.sent = '0;
    tx_line.collision = '0;
    tx_line.carrier = '0;
  endtask
endmodule // mrfts_medium_model

`default_nettype wire

// *** test/mrfts_props.sv ***
// Port-level checker for the filter and status block.
// Assumes a single clock domain; bound onto mrfts_top.
`timescale 1ns/1ps
`default_nettype none

module mrfts_props
  import mrfts_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                arst_n,
  input wire logic                ce,
  input wire mrfts_reg_req_type   reg_req,
  input wire logic [15:0]         reg_rdata,
  input wire mrfts_rx_report_type rx_rep,
  input wire mrfts_verdict_type   verdict,
  input wire logic                tx_cut,
  input wire logic                tx_bad_crc,
  input wire logic                tx_irq,
  input wire logic [15:0]         isq_word
);
  // ----------------------------------------------------------------
  // Frame verdict, register and transmit output checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_frame;
    ce && rx_rep.done;
  endsequence
  sequence s_long;
    ce && rx_rep.done && rx_rep.len > LEN_MAX_GOOD;
  endsequence

  property p_verdict_timing;
    s_frame |=> verdict.valid;
  endproperty
  a_verdict_timing: assert property (p_verdict_timing) else $error("verdict missing");
  property p_no_stray_verdict;
    ($past(ce) && verdict.valid) |-> $past(rx_rep.done);
  endproperty
  a_no_stray_verdict: assert property (p_no_stray_verdict) else $error("stray verdict");
  property p_tiny_drop;
    (ce && rx_rep.done && rx_rep.len < LEN_MIN_KEEP) |=> !verdict.accept;
  endproperty
  a_tiny_drop: assert property (p_tiny_drop) else $error("tiny frame kept");
  property p_long_cut;
    s_long |=> verdict.kept_len == LEN_MAX_GOOD;
  endproperty
  a_long_cut: assert property (p_long_cut) else $error("long length not cut");
  property p_len_pass;
    (ce && rx_rep.done && rx_rep.len <= LEN_MAX_GOOD) |=> verdict.kept_len == $past(rx_rep.len);
  endproperty
  a_len_pass: assert property (p_len_pass) else $error("length altered");
  property p_id_accept;
    (ce && reg_req.rd && reg_req.addr == OFS_ACCEPT) |=> reg_rdata[5:0] == ID_ACCEPT;
  endproperty
  a_id_accept: assert property (p_id_accept) else $error("bad id code");
  property p_id_events;
    (ce && reg_req.rd && reg_req.addr == OFS_EVENTS) |=> reg_rdata[5:0] == ID_EVENTS;
  endproperty
  a_id_events: assert property (p_id_events) else $error("bad event id code");
  property p_isq_id;
    tx_irq |-> isq_word[5:0] == ID_EVENTS;
  endproperty
  a_isq_id: assert property (p_isq_id) else $error("queue word id wrong");
  property p_bad_crc_cut;
    tx_bad_crc |-> tx_cut;
  endproperty
  a_bad_crc_cut: assert property (p_bad_crc_cut) else $error("bad checksum without cut");
endmodule // mrfts_props

bind mrfts_top mrfts_props mrfts_props_inst (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_rep(rx_rep), .verdict(verdict),
  .tx_cut(tx_cut), .tx_bad_crc(tx_bad_crc), .tx_irq(tx_irq), .isq_word(isq_word));

`default_nettype wire

// *** test/mac_rx_filter_tx_status_test.sv ***
// Self-checking bench: register bus, receive filter and transmit outcomes.
// Assumes short late and jabber limits; preload unused, ce held high.
`timescale 1ns/1ps
`default_nettype none

module mac_rx_filter_tx_status_test
  import mrfts_pkg::*;
;
  logic                ref_clk = 1'b0;
  logic                arst_n = 1'b0;
  mrfts_reg_req_type   reg_req = '0;
  mrfts_rx_report_type rx_rep = '0;
  mrfts_tx_line_type   tx_line;
  mrfts_verdict_type   verdict;
  logic [15:0]         reg_rdata;
  logic [15:0]         isq_word;
  logic                tx_cut;
  logic                tx_bad_crc;
  logic                tx_irq;
  int                  fails = 0;
  int                  tests_run = 0;
  int                  irqs = 0;
  int                  bads = 0;
  int                  cycles = 0;
  int                  n;
  localparam logic [47:0] STA = 48'h6655_4433_2210;
  localparam logic [47:0] UNI = 48'h0000_0000_1200;
  localparam logic [47:0] GRP = 48'h0000_0000_1201;

  always #5 ref_clk = ~ref_clk;

  // Small limits keep the late and jabber scenarios short
  mrfts_top #(.LATE_CYCLES(50), .JABBER_CYCLES(200)) mrfts_top_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .preload('0), .rx_rep(rx_rep), .verdict(verdict), .tx_line(tx_line), .tx_cut(tx_cut),
    .tx_bad_crc(tx_bad_crc), .tx_irq(tx_irq), .isq_word(isq_word));
  mrfts_medium_model mrfts_medium_model_inst (.ref_clk(ref_clk), .tx_line(tx_line));

  // Pulse counters and hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    irqs += (tx_irq === 1'b1);
    bads += (tx_bad_crc === 1'b1) + 2 * (tx_cut === 1'b1);
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 reg_req = {1'b0, 1'b1, a, d};
    @(posedge ref_clk);
    #1 reg_req = '0;
  endtask

  // Read data lands one cycle after the strobe edge
  task rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge ref_clk);
    #1 reg_req = {1'b1, 1'b0, a, 16'h0000};
    @(posedge ref_clk);
    #1 reg_req = '0;
    chk(reg_rdata & m, e);
  endtask

  task at(input logic f, a, c, input int y, k);
    mrfts_medium_model_inst.attempt(f, a, c, y, k);
  endtask

  task frm(input logic [15:0] cfg, input logic [47:0] d, input logic [15:0] len,
           input logic crc, hh, e);
    wr(OFS_ACCEPT, cfg);
    @(posedge ref_clk);
    #1 rx_rep = {1'b1, d, len, crc, hh};
    @(posedge ref_clk);
    #1 rx_rep.done = 1'b0;
    chk({14'h0, verdict.valid, verdict.accept}, {14'h0, 1'b1, e});
    chk(verdict.kept_len, (len > LEN_MAX_GOOD) ? LEN_MAX_GOOD : len);
  endtask

  task t_regs;
    rd(OFS_ACCEPT, 16'h0005);
    rd(OFS_TXEN, 16'h0007);
    rd(OFS_EVENTS, 16'h0008);
    rd(12'h200, 16'h0000);
    wr(OFS_ACCEPT, 16'hffff);
    rd(OFS_ACCEPT, 16'h7fc5);
    wr(OFS_TXEN, 16'hffff);
    rd(OFS_TXEN, 16'h8fc7);
    wr(OFS_EVENTS, 16'hffff);
    rd(OFS_EVENTS, 16'h0008);
    $display("register test done");
  endtask

  task t_filter;
    wr(OFS_STA0, STA[15:0]);
    wr(OFS_STA1, STA[31:16]);
    wr(OFS_STA2, STA[47:32]);
    frm(16'h0180, UNI, 16'd100, '1, '0, '1);
    frm(16'h0500, STA, 16'd64, '1, '0, '1);
    frm(16'h0500, UNI, 16'd1518, '1, '0, '0);
    frm(16'h0900, 48'hffff_ffff_ffff, 16'd1518, '1, '0, '1);
    frm(16'h0140, UNI, 16'd100, '1, '1, '1);
    frm(16'h0140, UNI, 16'd100, '1, '0, '0);
    frm(16'h0140, GRP, 16'd100, '1, '1, '0);
    frm(16'h0300, GRP, 16'd100, '1, '1, '1);
    frm(16'h0180, UNI, 16'd100, '0, '0, '0);
    frm(16'h1180, UNI, 16'd100, '0, '0, '1);
    frm(16'h0180, UNI, 16'd63, '1, '0, '0);
    frm(16'h2180, UNI, 16'd63, '1, '0, '1);
    frm(16'h2180, UNI, 16'd7, '1, '0, '0);
    frm(16'h2180, UNI, 16'd8, '1, '0, '1);
    frm(16'h0180, UNI, 16'd1519, '1, '0, '0);
    frm(16'h4180, UNI, 16'd2000, '1, '0, '1);
    $display("filter test done");
  endtask

  task t_tx_basic;
    wr(OFS_TXEN, 16'h0000);
    n = irqs;
    at('1, '0, '1, 20, 0);
    repeat (3) @(posedge ref_clk);
    chk(16'(irqs - n), 16'h0000);
    rd(OFS_EVENTS, 16'h0108);
    wr(OFS_TXEN, 16'hffff);
    n = irqs;
    at('1, '0, '1, 20, 0);
    repeat (3) @(posedge ref_clk);
    chk(16'(irqs - n), 16'h0001);
    chk(isq_word, 16'h0108);
    rd(OFS_EVENTS, 16'h0108);
    rd(OFS_EVENTS, 16'h0008);
    $display("success test done");
  endtask

  // Cut pulses count double in bads, so one late collision gives 3
  task t_tx_faults;
    at('1, '0, '1, 10, 1);
    at('0, '0, '1, 10, 1);
    at('0, '0, '1, 10, 0);
    rd(OFS_EVENTS, 16'h1108);
    n = bads;
    at('1, '0, '1, 60, 1);
    repeat (2) @(posedge ref_clk);
    chk(16'(bads - n), 16'h0003);
    rd(OFS_EVENTS, 16'h0208, 16'h87ff);
    n = bads;
    at('1, '0, '1, 250, 2);
    chk(16'(bads - n), 16'h0002);
    rd(OFS_EVENTS, 16'h0408);
    at('1, '0, '1, 10, 1);
    repeat (15) at('0, '0, '1, 10, 1);
    rd(OFS_EVENTS, 16'hf808);
    at('1, '1, '0, 10, 0);
    repeat (700) @(posedge ref_clk);
    rd(OFS_EVENTS, 16'h01c8);
    $display("fault test done");
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_filter();
    t_tx_basic();
    t_tx_faults();
    print_verdict();
  end
endmodule // mac_rx_filter_tx_status_test

`default_nettype wire
